// ==== shared/rx_buf_pkg.sv ====
/*
 Holds the word layout, field positions, register offsets and reset values of the receive message
 buffer store.
 Assumes a 16-bit word host register port and one controller clock.
*/
package rx_buf_pkg;
   localparam int WORD_W = 16;
   localparam int NUM_WORDS = 20;
   localparam int WORD_IDX_W = 5;
   localparam int PAY_WORDS = 16;
   localparam int PAY_IDX_W = 4;
   localparam int PAY_BYTES = 32;
   localparam logic [4:0] W_HDR0 = 5'h00;
   localparam logic [4:0] W_HDR1 = 5'h01;
   localparam logic [4:0] W_HDR2 = 5'h02;
   localparam logic [4:0] W_PAY0 = 5'h03;
   localparam logic [4:0] W_STATUS = 5'h13;
   localparam int FID_W = 11;
   localparam int FID_LSB = 0;
   localparam int BOOT_BIT = 11;
   localparam int ALIGN_BIT = 12;
   localparam int EMPTY_BIT = 13;
   localparam int PREAMBLE_BIT = 14;
   localparam int CYC_W = 6;
   localparam int CYC_LSB = 8;
   localparam int PLEN_W = 7;
   localparam int PLEN_LSB = 0;
   localparam int CRC_W = 11;
   localparam int CRC_LSB = 0;
   localparam int LO_BYTE_LSB = 0;
   localparam int HI_BYTE_LSB = 8;
   localparam int REG_ADDR_W = 8;
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] SEL_OFS = 8'h01;
   localparam logic [7:0] STAT_OFS = 8'h02;
   localparam logic [7:0] WIN_OFS = 8'h20;
   localparam int CFG_BIT = 0;
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [15:0] FID_RST = 16'h0000;
   localparam logic [15:0] ZERO_WORD = 16'h0000;
   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_W0 = 2'b01, ST_W1 = 2'b11, ST_W2 = 2'b10} store_state_t;
endpackage

// ==== shared/buf_mem_if.sv ====
/*
 Holds the bundle between the buffer store control logic and its word memory.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface buf_mem_if #(parameter int AW = 9);
   logic wr_en;
   logic [AW-1:0] wr_addr;
   logic [15:0] wr_data;
   logic rd_en;
   logic [AW-1:0] rd_addr;
   logic [15:0] rd_data;
   modport mem (input wr_en, input wr_addr, input wr_data, input rd_en, input rd_addr, output rd_data);
   modport ctl (output wr_en, output wr_addr, output wr_data, output rd_en, output rd_addr, input rd_data);
endinterface

// ==== hw/buf_word_mem.sv ====
/*
 Holds the word memory of all message buffers, one write and one read port.
 Assumes the controller clock; read data come from a register one cycle after rd_en.
*/
`timescale 1ns/10ps
module buf_word_mem #(
   parameter int DEPTH = 320
)
(
   // Clock
   input wire logic clk,
   // Memory bundle
   buf_mem_if.mem m
);
   logic [15:0] store [DEPTH];
   logic [15:0] rd_ff;

   always_ff @(posedge clk)
   begin
      if (m.wr_en)
      begin
         store[m.wr_addr] <= m.wr_data;
      end
   end

   always_ff @(posedge clk)
   begin
      if (m.rd_en)
      begin
         rd_ff <= store[m.rd_addr];
      end
   end

   assign m.rd_data = rd_ff;
endmodule

// ==== hw/hdr_pack.sv ====
/*
 Holds the packing of received header fields into the three header words of a buffer.
 Assumes field values arrive already checked by the protocol engine.
*/
`timescale 1ns/10ps
module hdr_pack (
   // Header fields
   input wire logic preamble,
   input wire logic empty,
   input wire logic align,
   input wire logic boot,
   input wire logic [5:0] cyc,
   input wire logic [6:0] plen,
   input wire logic [10:0] crc,
   // Packed words
   output logic [15:0] w0,
   output logic [15:0] w1,
   output logic [15:0] w2
);
   always_comb
   begin
      w0 = rx_buf_pkg::ZERO_WORD;
      w0[rx_buf_pkg::PREAMBLE_BIT] = preamble;
      w0[rx_buf_pkg::EMPTY_BIT] = empty;
      w0[rx_buf_pkg::ALIGN_BIT] = align;
      w0[rx_buf_pkg::BOOT_BIT] = boot;
      w1 = rx_buf_pkg::ZERO_WORD;
      w1[rx_buf_pkg::CYC_LSB +: rx_buf_pkg::CYC_W] = cyc;
      w1[rx_buf_pkg::PLEN_LSB +: rx_buf_pkg::PLEN_W] = plen;
      w2 = rx_buf_pkg::ZERO_WORD;
      w2[rx_buf_pkg::CRC_LSB +: rx_buf_pkg::CRC_W] = crc;
   end
endmodule

// ==== hw/rx_buf_store.sv ====
/*
 Holds the receive message buffer store: engine-side fill, host active window, frame ID config.
 Assumes a protocol engine that honours pe_ready and a host on the plain register port.
*/
`timescale 1ns/10ps
// Summary of operation
// - The host reaches buffer contents only through the active window selected by a buffer index.
// - Every buffer is twenty 16-bit words numbered 0 to 19.
// - Word 0 holds the 11-bit frame ID in bits 10..0 and the reserved bit and header flags above it.
// - The four header flags in word 0 come from the received header and are host read-only.
// - Word 1 holds the 6-bit cycle count in the upper byte and 7-bit payload length in the lower, read-only.
// - Word 2 holds the 11-bit header CRC in its low bits, read-only.
// - Words 3 to 18 hold payload bytes in pairs, even byte low and odd byte high, ending with byte 31.
// - Word 19 holds the slot status vector, host read-only.
// - The frame ID is host writable only in the configuration state, read-only otherwise.
// - The payload area is limited to 32 bytes, sixteen words.
// - Unused bits read as zero and are ignored by the controller.
module rx_buf_store #(
   parameter int NUM_BUF = 16,
   parameter int BUF_IDX_W = 4
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Host register port
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // Protocol engine header store
   input wire logic pe_hdr_valid,
   input wire logic [BUF_IDX_W-1:0] pe_buf,
   input wire logic payload_preamble_flag,
   input wire logic empty_frame_flag,
   input wire logic clock_align_flag,
   input wire logic boot_frame_flag,
   input wire logic [5:0] pe_cycle,
   input wire logic [6:0] pe_plen,
   input wire logic [10:0] pe_crc,
   // Protocol engine payload and status store
   input wire logic pe_pay_valid,
   input wire logic [3:0] pe_pay_idx,
   input wire logic [7:0] pe_byte_even,
   input wire logic [7:0] pe_byte_odd,
   input wire logic pe_stat_valid,
   input wire logic [15:0] pe_stat,
   output logic pe_ready,
   // Configuration state seen by other blocks
   output logic config_state
);
   localparam int AW = $clog2(NUM_BUF * rx_buf_pkg::NUM_WORDS);

   buf_mem_if #(.AW(AW)) mif ();

   rx_buf_pkg::store_state_t state_ff;
   rx_buf_pkg::store_state_t nxt_state;
   logic [BUF_IDX_W-1:0] hbuf_ff;
   logic [15:0] w1_ff;
   logic [15:0] w2_ff;
   logic [15:0] w0_ff;
   logic [15:0] p_w0;
   logic [15:0] p_w1;
   logic [15:0] p_w2;
   logic cfg_ff;
   logic [BUF_IDX_W-1:0] sel_ff;
   logic [BUF_IDX_W-1:0] last_buf_ff;
   logic [10:0] fid_ff [NUM_BUF];
   logic [10:0] fid_rd_ff;
   logic win_rd_ff;
   logic fid_merge_ff;
   logic [15:0] ctl_rd_ff;
   logic ready_ff;
   logic win_hit;
   logic [4:0] win_word;
   logic [AW-1:0] win_base;
   logic [AW-1:0] pe_base;

   hdr_pack u_pack (
      .preamble(payload_preamble_flag),
      .empty(empty_frame_flag),
      .align(clock_align_flag),
      .boot(boot_frame_flag),
      .cyc(pe_cycle),
      .plen(pe_plen),
      .crc(pe_crc),
      .w0(p_w0),
      .w1(p_w1),
      .w2(p_w2)
   );

   buf_word_mem #(.DEPTH(NUM_BUF * rx_buf_pkg::NUM_WORDS)) u_mem (
      .clk(clk),
      .m(mif)
   );

   // Buffers sit at a fixed stride of twenty words in one memory.
   assign win_base = AW'(sel_ff * rx_buf_pkg::NUM_WORDS);
   assign win_word = 5'(reg_addr - rx_buf_pkg::WIN_OFS);
   assign win_hit = (reg_addr >= rx_buf_pkg::WIN_OFS) &&
                    (reg_addr < 8'(rx_buf_pkg::WIN_OFS + rx_buf_pkg::NUM_WORDS));

   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         rx_buf_pkg::ST_IDLE:
         begin
            if (ready_ff && pe_hdr_valid)
            begin
               nxt_state = rx_buf_pkg::ST_W0;
            end
         end
         rx_buf_pkg::ST_W0:
            nxt_state = rx_buf_pkg::ST_W1;
         rx_buf_pkg::ST_W1:
            nxt_state = rx_buf_pkg::ST_W2;
         rx_buf_pkg::ST_W2:
            nxt_state = rx_buf_pkg::ST_IDLE;
         default:
            nxt_state = rx_buf_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_ff <= rx_buf_pkg::ST_IDLE;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   // Header fields are held so the three header words go out on consecutive cycles.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         hbuf_ff <= '0;
         w0_ff <= rx_buf_pkg::ZERO_WORD;
         w1_ff <= rx_buf_pkg::ZERO_WORD;
         w2_ff <= rx_buf_pkg::ZERO_WORD;
      end
      // The first cycle after reset is idle but not ready, so a header offered there is refused.
      else if (state_ff == rx_buf_pkg::ST_IDLE && ready_ff && pe_hdr_valid)
      begin
         hbuf_ff <= pe_buf;
         w0_ff <= p_w0;
         w1_ff <= p_w1;
         w2_ff <= p_w2;
      end
   end

   // The engine may store only while idle; pe_ready is registered from the next state, so it is high in the idle cycles themselves.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ready_ff <= 1'b0;
      end
      else
      begin
         ready_ff <= (nxt_state == rx_buf_pkg::ST_IDLE);
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         last_buf_ff <= '0;
      end
      else if (state_ff == rx_buf_pkg::ST_W2)
      begin
         last_buf_ff <= hbuf_ff;
      end
   end

   assign pe_base = AW'((state_ff == rx_buf_pkg::ST_IDLE ? pe_buf : hbuf_ff) * rx_buf_pkg::NUM_WORDS);

   // Word 0 in memory carries only flags; the frame ID lives in its own registers.
   always_comb
   begin
      mif.wr_en = 1'b0;
      mif.wr_addr = pe_base;
      mif.wr_data = rx_buf_pkg::ZERO_WORD;
      case (state_ff)
         rx_buf_pkg::ST_W0:
         begin
            mif.wr_en = 1'b1;
            mif.wr_addr = AW'(pe_base + rx_buf_pkg::W_HDR0);
            mif.wr_data = w0_ff;
         end
         rx_buf_pkg::ST_W1:
         begin
            mif.wr_en = 1'b1;
            mif.wr_addr = AW'(pe_base + rx_buf_pkg::W_HDR1);
            mif.wr_data = w1_ff;
         end
         rx_buf_pkg::ST_W2:
         begin
            mif.wr_en = 1'b1;
            mif.wr_addr = AW'(pe_base + rx_buf_pkg::W_HDR2);
            mif.wr_data = w2_ff;
         end
         default:
         begin
            if (ready_ff && !pe_hdr_valid && pe_pay_valid)
            begin
               mif.wr_en = 1'b1;
               // A 4-bit word index cannot pass the sixteenth payload word.
               mif.wr_addr = AW'(pe_base + rx_buf_pkg::W_PAY0 + 5'(pe_pay_idx));
               mif.wr_data = {pe_byte_odd, pe_byte_even};
            end
            else if (ready_ff && !pe_hdr_valid && pe_stat_valid)
            begin
               mif.wr_en = 1'b1;
               mif.wr_addr = AW'(pe_base + rx_buf_pkg::W_STATUS);
               mif.wr_data = pe_stat;
            end
         end
      endcase
   end

   // Host reads of the window go to memory; host writes never do.
   assign mif.rd_en = reg_rd && win_hit;
   assign mif.rd_addr = AW'(win_base + win_word);

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cfg_ff <= rx_buf_pkg::CTRL_RST[rx_buf_pkg::CFG_BIT];
         sel_ff <= '0;
      end
      else if (reg_wr)
      begin
         if (reg_addr == rx_buf_pkg::CTRL_OFS)
         begin
            cfg_ff <= reg_wdata[rx_buf_pkg::CFG_BIT];
         end
         if (reg_addr == rx_buf_pkg::SEL_OFS)
         begin
            sel_ff <= BUF_IDX_W'(reg_wdata);
         end
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         for (int i = 0; i < NUM_BUF; i++)
         begin
            fid_ff[i] <= rx_buf_pkg::FID_RST[10:0];
         end
      end
      else if (reg_wr && cfg_ff && win_hit && win_word == rx_buf_pkg::W_HDR0)
      begin
         fid_ff[sel_ff] <= reg_wdata[rx_buf_pkg::FID_LSB +: rx_buf_pkg::FID_W];
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         win_rd_ff <= 1'b0;
         fid_merge_ff <= 1'b0;
         fid_rd_ff <= '0;
         ctl_rd_ff <= rx_buf_pkg::ZERO_WORD;
      end
      else
      begin
         win_rd_ff <= reg_rd && win_hit;
         fid_merge_ff <= reg_rd && win_hit && win_word == rx_buf_pkg::W_HDR0;
         fid_rd_ff <= fid_ff[sel_ff];
         ctl_rd_ff <= rx_buf_pkg::ZERO_WORD;
         if (reg_rd && reg_addr == rx_buf_pkg::CTRL_OFS)
         begin
            ctl_rd_ff[rx_buf_pkg::CFG_BIT] <= cfg_ff;
         end
         else if (reg_rd && reg_addr == rx_buf_pkg::SEL_OFS)
         begin
            ctl_rd_ff <= 16'(sel_ff);
         end
         else if (reg_rd && reg_addr == rx_buf_pkg::STAT_OFS)
         begin
            ctl_rd_ff <= {~ready_ff, 7'h00, 8'(last_buf_ff)};
         end
      end
   end

   // Read data is a mux of registered sources so the window costs no extra cycle.
   always_comb
   begin
      reg_rdata = ctl_rd_ff;
      if (win_rd_ff)
      begin
         reg_rdata = mif.rd_data;
      end
      if (fid_merge_ff)
      begin
         reg_rdata[rx_buf_pkg::FID_LSB +: rx_buf_pkg::FID_W] = fid_rd_ff;
      end
   end

   assign pe_ready = ready_ff;
   assign config_state = cfg_ff;
endmodule

// ==== testbench/rx_buf_store_sva.sv ====
/*
 Holds the port checker of the receive buffer store.
 Assumes it is bound to rx_buf_store and sees only its ports.
*/
`timescale 1ns/10ps
module rx_buf_store_sva (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Host register port
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   // Engine handshake and state
   input wire logic pe_hdr_valid,
   input wire logic pe_ready,
   input wire logic config_state
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   property p_rd_idle;
      !reg_rd |=> reg_rdata == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data without a read");
   property p_hdr_busy;
      pe_ready && pe_hdr_valid |=> !pe_ready [*3] ##1 pe_ready;
   endproperty
   a_hdr_busy: assert property (p_hdr_busy) else $error("header store timing wrong");
   property p_cfg_set;
      reg_wr && reg_addr == rx_buf_pkg::CTRL_OFS |=> config_state == $past(reg_wdata[rx_buf_pkg::CFG_BIT]);
   endproperty
   a_cfg_set: assert property (p_cfg_set) else $error("config state not written");
   property p_cfg_hold;
      !(reg_wr && reg_addr == rx_buf_pkg::CTRL_OFS) |=> $stable(config_state);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("config state changed alone");
   property p_w0_top;
      reg_rd && reg_addr == rx_buf_pkg::WIN_OFS |=> reg_rdata[15] == 1'b0;
   endproperty
   a_w0_top: assert property (p_w0_top) else $error("word 0 reserved bit set");
   property p_w1_unused;
      reg_rd && reg_addr == rx_buf_pkg::WIN_OFS + 8'h01 |=> reg_rdata[15:14] == 2'b00 && reg_rdata[7] == 1'b0;
   endproperty
   a_w1_unused: assert property (p_w1_unused) else $error("word 1 unused bits set");
   property p_w2_unused;
      reg_rd && reg_addr == rx_buf_pkg::WIN_OFS + 8'h02 |=> reg_rdata[15:11] == 5'h00;
   endproperty
   a_w2_unused: assert property (p_w2_unused) else $error("word 2 unused bits set");
   property p_unmapped;
      reg_rd && reg_addr > rx_buf_pkg::WIN_OFS + 8'h13 |=> reg_rdata == 16'h0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("read past word 19 not zero");
endmodule
bind rx_buf_store rx_buf_store_sva chk (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pe_hdr_valid(pe_hdr_valid), .pe_ready(pe_ready),
   .config_state(config_state));

// ==== testbench/rx_fill_engine.sv ====
/*
 Holds a protocol engine model that stores received frames into the buffer store.
 Assumes one clock; every request is held until an edge that sees pe_ready high, or for at most 50 edges.
*/
`timescale 1ns/10ps
module rx_fill_engine (
   // Clock and handshake
   input wire logic clk,
   input wire logic pe_ready,
   output logic pe_hdr_valid,
   output logic pe_pay_valid,
   output logic pe_stat_valid,
   // Store fields
   output logic [3:0] pe_buf,
   output logic [3:0] flags,
   output logic [5:0] pe_cycle,
   output logic [6:0] pe_plen,
   output logic [10:0] pe_crc,
   output logic [3:0] pe_pay_idx,
   output logic [7:0] pe_byte_even,
   output logic [7:0] pe_byte_odd,
   output logic [15:0] pe_stat
);
   initial
   begin
      {pe_hdr_valid, pe_pay_valid, pe_stat_valid, pe_buf, flags, pe_cycle, pe_plen} = '0;
      {pe_crc, pe_pay_idx, pe_byte_even, pe_byte_odd, pe_stat} = '0;
   end
   task automatic take();
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (!pe_ready && n < 50);
   endtask
   // Released header, status and buffer index lines show inverted data, payload bytes only in slow mode, so a stale value is never mistaken for a store.
   task automatic store(input logic [3:0] b, input logic [3:0] fl, input logic [5:0] c, input logic [6:0] pl,
      input logic [10:0] cr, input logic [15:0] pay [16], input logic [15:0] st, input logic slow);
      @(posedge clk);
      pe_buf <= b;
      {flags, pe_cycle, pe_plen, pe_crc} <= {fl, c, pl, cr};
      pe_hdr_valid <= 1'b1;
      take();
      pe_hdr_valid <= 1'b0;
      {flags, pe_cycle, pe_plen, pe_crc} <= ~{fl, c, pl, cr};
      for (int i = 0; i < 16; i++)
      begin
         pe_pay_valid <= 1'b1;
         pe_pay_idx <= i[3:0];
         {pe_byte_odd, pe_byte_even} <= pay[i];
         take();
         if (slow)
         begin
            pe_pay_valid <= 1'b0;
            {pe_byte_odd, pe_byte_even} <= ~pay[i];
            @(posedge clk);
         end
      end
      pe_pay_valid <= 1'b0;
      pe_stat_valid <= 1'b1;
      pe_stat <= st;
      take();
      pe_stat_valid <= 1'b0;
      pe_stat <= ~st;
      pe_buf <= ~b;
   endtask
endmodule

// ==== testbench/rx_buf_store_tb.sv ====
/*
 Holds the self-checking bench of the receive buffer store with a word model.
 Assumes the engine model fills buffers and the host port reads them back.
*/
`timescale 1ns/10ps
module rx_buf_store_tb;
   logic clk, rstn, reg_wr, reg_rd, pe_hdr_valid, pe_pay_valid, pe_stat_valid, pe_ready, config_state;
   logic [7:0] reg_addr, pe_byte_even, pe_byte_odd;
   logic [15:0] reg_wdata, reg_rdata, pe_stat;
   logic [3:0] pe_buf, flags, pe_pay_idx;
   logic [5:0] pe_cycle;
   logic [6:0] pe_plen;
   logic [10:0] pe_crc;
   logic [31:0] seed;
   int failures, cmp_count, cycles;
   logic [15:0] exp_w [4][20];
   rx_buf_store dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pe_hdr_valid(pe_hdr_valid), .pe_buf(pe_buf),
      .payload_preamble_flag(flags[3]), .empty_frame_flag(flags[2]), .clock_align_flag(flags[1]),
      .boot_frame_flag(flags[0]), .pe_cycle(pe_cycle), .pe_plen(pe_plen), .pe_crc(pe_crc),
      .pe_pay_valid(pe_pay_valid), .pe_pay_idx(pe_pay_idx), .pe_byte_even(pe_byte_even),
      .pe_byte_odd(pe_byte_odd), .pe_stat_valid(pe_stat_valid), .pe_stat(pe_stat), .pe_ready(pe_ready),
      .config_state(config_state));
   rx_fill_engine eng (.clk(clk), .pe_ready(pe_ready), .pe_hdr_valid(pe_hdr_valid), .pe_pay_valid(pe_pay_valid),
      .pe_stat_valid(pe_stat_valid), .pe_buf(pe_buf), .flags(flags), .pe_cycle(pe_cycle), .pe_plen(pe_plen),
      .pe_crc(pe_crc), .pe_pay_idx(pe_pay_idx), .pe_byte_even(pe_byte_even), .pe_byte_odd(pe_byte_odd),
      .pe_stat(pe_stat));
   function automatic logic [31:0] nxt_rand(input logic [31:0] s);
      for (int i = 0; i < 16; i++)
         s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
      return s;
   endfunction
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input string what);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(what, exp, reg_rdata);
   endtask
   // Fills buffer 5*b with random header, payload and status, and records the image.
   task automatic fill(input int b);
      logic [15:0] pay [16];
      logic [31:0] hs;
      seed = nxt_rand(seed);
      // The header draw is kept apart, since the payload draws move the seed on.
      hs = seed;
      exp_w[b][0] = {1'b0, hs[19:16], 11'h000};
      exp_w[b][1] = {2'b00, hs[9:4], 1'b0, hs[16:10]};
      exp_w[b][2] = {5'h00, hs[27:17]};
      exp_w[b][19] = hs[31:16];
      for (int i = 0; i < 16; i++)
      begin
         seed = nxt_rand(seed);
         pay[i] = seed[15:0];
         exp_w[b][3 + i] = pay[i];
      end
      eng.store(4'(5 * b), hs[19:16], hs[9:4], hs[16:10], hs[27:17], pay, exp_w[b][19], hs[20]);
   endtask
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         end_of_test();
      end
   end
   initial
   begin
      {rstn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      seed = 32'h3be5_014c;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      rd_chk(rx_buf_pkg::CTRL_OFS, rx_buf_pkg::CTRL_RST, "ctrl reset");
      for (int b = 0; b < 4; b++)
         fill(b);
      rd_chk(rx_buf_pkg::STAT_OFS, 16'h000f, "store status");
      for (int b = 0; b < 4; b++)
      begin
         wr(rx_buf_pkg::SEL_OFS, 16'(5 * b));
         for (int w = 0; w < 20; w++)
            rd_chk(rx_buf_pkg::WIN_OFS + 8'(w), exp_w[b][w], "window word");
      end
      wr(rx_buf_pkg::WIN_OFS, 16'hffff);
      rd_chk(rx_buf_pkg::WIN_OFS, exp_w[3][0], "locked frame id");
      wr(rx_buf_pkg::CTRL_OFS, 16'h0001);
      rd_chk(rx_buf_pkg::CTRL_OFS, 16'h0001, "ctrl");
      wr(rx_buf_pkg::WIN_OFS, 16'hffff);
      wr(rx_buf_pkg::WIN_OFS + 8'h01, 16'h0000);
      wr(rx_buf_pkg::WIN_OFS + 8'h13, 16'h0000);
      rd_chk(rx_buf_pkg::WIN_OFS, exp_w[3][0] | 16'h07ff, "config frame id");
      rd_chk(rx_buf_pkg::WIN_OFS + 8'h01, exp_w[3][1], "word 1 kept");
      rd_chk(rx_buf_pkg::WIN_OFS + 8'h13, exp_w[3][19], "status kept");
      wr(rx_buf_pkg::CTRL_OFS, 16'h0000);
      rd_chk(8'h34, 16'h0000, "past window");
      rd_chk(8'h10, 16'h0000, "unmapped");
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      rd_chk(rx_buf_pkg::CTRL_OFS, rx_buf_pkg::CTRL_RST, "ctrl after reset");
      wr(rx_buf_pkg::SEL_OFS, 16'h000f);
      rd_chk(rx_buf_pkg::WIN_OFS, exp_w[3][0], "frame id after reset");
      end_of_test();
   end
endmodule
